// File: verilog/tlipu_top.sv
// Two-level interrupt priority unit: flags, gating, priority, vectoring, return.
// Assumes the core fetch logic obeys the vector strobe and reports return instructions.
// Operation
// - High priority vectors to 0008h, low priority to 0018h.
// - Pending enabled high request preempts a running low service.
// - Each source has a flag, an enable and a priority select.
// - Two-level mode only while the priority-levels enable bit is set.
// - Control bit 7 globally enables high sources in two-level mode.
// - Control bit 6 globally enables low sources in two-level mode.
// - Flag, enable and global enable all set vectors at once.
// - Priority enable clear by default gives compatibility mode, priority ignored.
// - In compatibility mode bit 6 gates all peripheral sources.
// - In compatibility mode bit 7 is the master enable.
// - Compatibility mode uses only vector 0008h.
// - Acceptance clears the governing global enable.
// - Low requests are held off while high service runs.
// - Taking an interrupt pushes return address and loads the vector.
// - Flags stay set until software clears them.
// - Return instruction leaves service and sets the enable cleared on entry.
// - External events vector three to four instruction cycles later.
// - External latency is independent of instruction length.
// - Flags set regardless of individual or global enables.
// - Interrupt wake-up with its global enable set copies PC to stack top and advances the pointer.
// - Interrupt wake-up with its global enable set loads the high or low vector.
// - Interrupt wake-up leaves the causing flags set.
`include "tlipu_params.svh"
module tlipu_top
  import tlipu_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [`TLIPU_NSRC-1:0] SRC_EVENT,
  input wire logic [`TLIPU_NSRC-1:0] SRC_EXT,
  input wire logic [`TLIPU_NSRC-1:0] FLAG_CLEAR,
  input wire logic [`TLIPU_NSRC-1:0] SRC_ENABLE,
  input wire logic [`TLIPU_NSRC-1:0] SRC_PRIORITY,
  input wire logic [`TLIPU_NSRC-1:0] SRC_IS_PERIPH,
  input wire logic PRIO_LEVELS_WR,
  input wire logic PRIO_LEVELS_VAL,
  input wire logic GIE_HIGH_WR,
  input wire logic GIE_HIGH_VAL,
  input wire logic GIE_LOW_WR,
  input wire logic GIE_LOW_VAL,
  input wire logic RETURN_FROM_IRQ_INSTR,
  input wire logic SLEEPING,
  input wire logic [`TLIPU_PC_W-1:0] CURRENT_PC,
  output logic [`TLIPU_NSRC-1:0] FLAGS,
  output logic PRIORITY_LEVELS_ENABLE,
  output logic HIGH_LEVEL_GLOBAL_ENABLE,
  output logic LOW_LEVEL_GLOBAL_ENABLE,
  output logic VECTOR_LOAD,
  output logic [`TLIPU_PC_W-1:0] VECTOR_ADDR,
  output logic [`TLIPU_PC_W-1:0] STACK_TOP,
  output logic [`TLIPU_SP_W-1:0] STACK_POINTER,
  output logic WAKE,
  output tlipu_svc_t SERVICE_STATE
);
  logic [`TLIPU_NSRC-1:0] flag_w;
  logic [`TLIPU_NSRC-1:0] ext_d1_reg, ext_d2_reg, ext_d1_next, ext_d2_next;
  logic [`TLIPU_NSRC-1:0] evt_w;
  tlipu_src_t src;
  logic prio_reg, prio_next, gh_reg, gh_next, gl_reg, gl_next;
  tlipu_svc_t svc_reg, svc_next;
  logic vload_reg, vload_next, wake_reg, wake_next;
  logic [`TLIPU_PC_W-1:0] vec_reg, vec_next, tos_reg, tos_next;
  logic [`TLIPU_SP_W-1:0] sp_reg, sp_next;
  logic req_high, req_low, take_high, take_low, any_pending;

  // External events pass a two-stage pipe so the vector lands 3-4 cycles after them,
  // independent of what the core is executing
  always_comb begin
    ext_d1_next = SRC_EXT;
    ext_d2_next = ext_d1_reg;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ext_d1_reg <= `TLIPU_NSRC_ZERO;
      ext_d2_reg <= `TLIPU_NSRC_ZERO;
    end else begin
      ext_d1_reg <= ext_d1_next;
      ext_d2_reg <= ext_d2_next;
    end
  end
  // The external pulse is gone by the time it leaves the pipe, so the delayed copy
  // must not be masked by the live pin
  assign evt_w = SRC_EVENT | ext_d2_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `TLIPU_NSRC; gi++) begin : g_flag
      // Flag ignores enables entirely
      tlipu_flag u_flag (
        .clk(CLK),
        .nrst(NRST),
        .evt(evt_w[gi]),
        .clr(FLAG_CLEAR[gi]),
        .flag(flag_w[gi])
      );
    end
  endgenerate

  always_comb begin
    src.flag = flag_w;
    src.enable = SRC_ENABLE;
    src.prio = SRC_PRIORITY;
    src.periph = SRC_IS_PERIPH;
    if (prio_reg) begin
      req_high = gh_reg & |(src.flag & src.enable & src.prio);
      req_low = gl_reg & |(src.flag & src.enable & ~src.prio);
    end else begin
      // Priority bits ignored; bit 6 gates peripheral sources only
      req_high = gh_reg & |(src.flag & src.enable & (~src.periph | {`TLIPU_NSRC{gl_reg}}));
      req_low = 1'b0;
    end
    any_pending = |(src.flag & src.enable);
    take_high = req_high & (svc_reg != TLIPU_IN_HIGH) & (svc_reg != TLIPU_IN_BOTH);
    // High wins a tie; low waits while high service runs
    take_low = req_low & ~req_high & (svc_reg == TLIPU_IDLE);
  end

  always_comb begin
    prio_next = PRIO_LEVELS_WR ? PRIO_LEVELS_VAL : prio_reg;
    gh_next = GIE_HIGH_WR ? GIE_HIGH_VAL : gh_reg;
    gl_next = GIE_LOW_WR ? GIE_LOW_VAL : gl_reg;
    svc_next = svc_reg;
    vload_next = 1'b0;
    vec_next = vec_reg;
    tos_next = tos_reg;
    sp_next = sp_reg;
    wake_next = SLEEPING & any_pending;
    if (RETURN_FROM_IRQ_INSTR) begin
      // Restore the enable of the level being left
      if (!prio_reg) begin
        gh_next = 1'b1;
        svc_next = TLIPU_IDLE;
      end else if (svc_reg == TLIPU_IN_BOTH) begin
        gh_next = 1'b1;
        svc_next = TLIPU_IN_LOW;
      end else if (svc_reg == TLIPU_IN_HIGH) begin
        gh_next = 1'b1;
        svc_next = TLIPU_IDLE;
      end else if (svc_reg == TLIPU_IN_LOW) begin
        gl_next = 1'b1;
        svc_next = TLIPU_IDLE;
      end
      sp_next = sp_reg - `TLIPU_SP_ONE;
    end else if (take_high | take_low) begin
      vload_next = 1'b1;
      tos_next = CURRENT_PC;
      sp_next = sp_reg + `TLIPU_SP_ONE;
      if (take_high) begin
        vec_next = `TLIPU_VEC_HIGH;
        gh_next = 1'b0;
        svc_next = (svc_reg == TLIPU_IN_LOW) ? TLIPU_IN_BOTH : TLIPU_IN_HIGH;
      end else begin
        vec_next = `TLIPU_VEC_LOW;
        gl_next = 1'b0;
        svc_next = TLIPU_IN_LOW;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prio_reg <= 1'b0;
      gh_reg <= 1'b0;
      gl_reg <= 1'b0;
      svc_reg <= TLIPU_IDLE;
      vload_reg <= 1'b0;
      vec_reg <= `TLIPU_PC_ZERO;
      tos_reg <= `TLIPU_PC_ZERO;
      sp_reg <= `TLIPU_SP_ZERO;
      wake_reg <= 1'b0;
    end else begin
      prio_reg <= prio_next;
      gh_reg <= gh_next;
      gl_reg <= gl_next;
      svc_reg <= svc_next;
      vload_reg <= vload_next;
      vec_reg <= vec_next;
      tos_reg <= tos_next;
      sp_reg <= sp_next;
      wake_reg <= wake_next;
    end
  end

  assign FLAGS = flag_w;
  assign PRIORITY_LEVELS_ENABLE = prio_reg;
  assign HIGH_LEVEL_GLOBAL_ENABLE = gh_reg;
  assign LOW_LEVEL_GLOBAL_ENABLE = gl_reg;
  assign VECTOR_LOAD = vload_reg;
  assign VECTOR_ADDR = vec_reg;
  assign STACK_TOP = tos_reg;
  assign STACK_POINTER = sp_reg;
  assign WAKE = wake_reg;
  assign SERVICE_STATE = svc_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  high_vec_a: assert property (take_high |=> VECTOR_LOAD && VECTOR_ADDR == `TLIPU_VEC_HIGH)
    else $error("high take did not load high vector");
  low_vec_a: assert property (take_low |=> VECTOR_LOAD && VECTOR_ADDR == `TLIPU_VEC_LOW)
    else $error("low take did not load low vector");
  compat_vec_a: assert property (VECTOR_LOAD && !$past(prio_reg) |-> VECTOR_ADDR == `TLIPU_VEC_HIGH)
    else $error("compatibility mode used low vector");
  entry_clr_a: assert property (take_high && !RETURN_FROM_IRQ_INSTR |=> !gh_reg)
    else $error("high enable not cleared on entry");
  low_hold_a: assert property (svc_reg == TLIPU_IN_HIGH |-> !take_low)
    else $error("low taken during high service");
  tie_high_a: assert property (req_high && req_low && take_high |=> VECTOR_ADDR == `TLIPU_VEC_HIGH)
    else $error("tie not resolved to high");
  push_sp_a: assert property (VECTOR_LOAD |-> STACK_POINTER == $past(sp_reg) + `TLIPU_SP_ONE)
    else $error("stack pointer not advanced");
  flag_hold_a: assert property (flag_w[0] && !FLAG_CLEAR[0] |=> flag_w[0])
    else $error("flag dropped without clear");
  ext_lat_a: assert property (SRC_EXT[0] |-> ##3 flag_w[0])
    else $error("external flag late");
  ret_en_a: assert property (RETURN_FROM_IRQ_INSTR && svc_reg == TLIPU_IN_LOW && prio_reg |=> gl_reg)
    else $error("return did not restore low enable");
  compat_nolow_a: assert property (!prio_reg |-> !take_low)
    else $error("low level taken in compatibility mode");
  wake_lvl_a: assert property (SLEEPING && any_pending |=> WAKE)
    else $error("wake not raised for pending source");
  ret_sp_a: assert property (RETURN_FROM_IRQ_INSTR |=> STACK_POINTER == $past(sp_reg) - `TLIPU_SP_ONE)
    else $error("stack pointer not restored on return");
  flag_set_a: assert property (evt_w[0] |=> flag_w[0])
    else $error("event did not set flag");
  tos_copy_a: assert property ((take_high || take_low) && !RETURN_FROM_IRQ_INSTR |=> STACK_TOP == $past(CURRENT_PC))
    else $error("return address not pushed");
  tie_c: cover property (req_high && req_low && take_high);
  preempt_c: cover property (svc_reg == TLIPU_IN_LOW ##1 svc_reg == TLIPU_IN_BOTH);
  compat_c: cover property (!prio_reg && VECTOR_LOAD);
  wake_c: cover property (WAKE ##[1:8] VECTOR_LOAD);
endmodule

// File: include/tlipu_params.svh
// Constants for the two-level interrupt priority unit.
// Assumes inclusion by bare name from the design and bench files.
`ifndef TLIPU_PARAMS_SVH
`define TLIPU_PARAMS_SVH
`define TLIPU_NSRC 8
`define TLIPU_PC_W 21
`define TLIPU_SP_W 5
`define TLIPU_VEC_HIGH 21'h000008
`define TLIPU_VEC_LOW 21'h000018
`define TLIPU_CTL_GH 7
`define TLIPU_CTL_GL 6
`define TLIPU_RST_PRIO 7
`define TLIPU_EXT_SYNC 2
`define TLIPU_SP_ONE 5'h01
`define TLIPU_NSRC_ZERO 8'h00
`define TLIPU_PC_ZERO 21'h000000
`define TLIPU_SP_ZERO 5'h00
`endif

// File: include/tlipu_pkg.sv
// Types shared by the interrupt priority unit and its bench.
// Assumes tlipu_params.svh is on the include path.
`include "tlipu_params.svh"
package tlipu_pkg;
  typedef struct packed {
    logic [`TLIPU_NSRC-1:0] flag;
    logic [`TLIPU_NSRC-1:0] enable;
    logic [`TLIPU_NSRC-1:0] prio;
    logic [`TLIPU_NSRC-1:0] periph;
  } tlipu_src_t;
  typedef struct packed {
    logic push;
    logic [`TLIPU_PC_W-1:0] ret_addr;
    logic [`TLIPU_PC_W-1:0] vector;
  } tlipu_vec_t;
  typedef enum logic [1:0] {TLIPU_IDLE, TLIPU_IN_LOW, TLIPU_IN_HIGH, TLIPU_IN_BOTH} tlipu_svc_t;
endpackage

// File: verilog/tlipu_flag.sv
// One sticky source flag: set by its event, cleared by software.
// Assumes event and clear are synchronous one-cycle pulses.
module tlipu_flag (
  input wire logic clk,
  input wire logic nrst,
  input wire logic evt,
  input wire logic clr,
  output logic flag
);
  logic flag_next;
  always_comb begin
    // Set beats clear so a coincident event is never lost
    flag_next = evt | (flag & ~clr);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else begin
      flag <= flag_next;
    end
  end
endmodule

// File: verif/tlipu_core_model.sv
// Core-side model: program counter plus a small return stack.
// Assumes load comes from the unit and ret from the bench, each one cycle.
`include "tlipu_params.svh"
module tlipu_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic ret,
  input wire logic [`TLIPU_PC_W-1:0] vec,
  output logic [`TLIPU_PC_W-1:0] pc
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [`TLIPU_PC_W-1:0] stk [4];
  logic [1:0] sp;
  // PC stands still between vectors so the pushed address is predictable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc <= 21'h000100;
      sp <= 2'h0;
    end else if (load) begin
      stk[sp] <= pc;
      sp <= sp + 2'h1;
      pc <= vec;
    end else if (ret) begin
      sp <= sp - 2'h1;
      pc <= stk[sp - 2'h1];
    end
  end
endmodule

// File: verif/tb.sv
// Bench for the interrupt priority unit: scenario calls with expected values.
// Assumes the core model on the PC side and the bench on all other inputs.
`include "tlipu_params.svh"
module tb
  import tlipu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [7:0] se = 8'h00, sx = 8'h00, fc = 8'h00, en = 8'hfd, pr = 8'h51, pe = 8'h04;
  logic [2:0] w = 3'h0, v = 3'h0;
  logic rt = 1'b0, slp = 1'b0;
  logic [20:0] pc, va, st;
  logic [7:0] fl;
  logic [4:0] sp;
  logic ple, gh, gl, vl, wk;
  tlipu_svc_t ss;
  int err_total = 0;
  int total_checks = 0;
  always #12.5 CLK = ~CLK;
  tlipu_top DUT (.CLK(CLK), .NRST(NRST), .SRC_EVENT(se), .SRC_EXT(sx), .FLAG_CLEAR(fc),
    .SRC_ENABLE(en), .SRC_PRIORITY(pr), .SRC_IS_PERIPH(pe),
    .PRIO_LEVELS_WR(w[2]), .PRIO_LEVELS_VAL(v[2]), .GIE_HIGH_WR(w[1]), .GIE_HIGH_VAL(v[1]),
    .GIE_LOW_WR(w[0]), .GIE_LOW_VAL(v[0]), .RETURN_FROM_IRQ_INSTR(rt), .SLEEPING(slp),
    .CURRENT_PC(pc), .FLAGS(fl), .PRIORITY_LEVELS_ENABLE(ple), .HIGH_LEVEL_GLOBAL_ENABLE(gh),
    .LOW_LEVEL_GLOBAL_ENABLE(gl), .VECTOR_LOAD(vl), .VECTOR_ADDR(va), .STACK_TOP(st),
    .STACK_POINTER(sp), .WAKE(wk), .SERVICE_STATE(ss));
  tlipu_core_model core (.clk(CLK), .nrst(NRST), .load(vl), .ret(rt), .vec(va), .pc(pc));
  task give_verdict();
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Clear, return and control writes share one cycle-wide strobe
  task strobe(logic [7:0] c, logic r, logic [2:0] wm, logic [2:0] vm);
    @(posedge CLK);
    fc <= c;
    rt <= r;
    w <= wm;
    v <= vm;
    @(posedge CLK);
    fc <= 8'h00;
    rt <= 1'b0;
    w <= 3'h0;
    #1;
  endtask
  // e: expected cycles to the vector, 8 means none, 0 means do not time it
  task wv(int e, logic [20:0] a);
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      se <= 8'h00;
      sx <= 8'h00;
      #1;
      n++;
    end while (vl !== 1'b1 && n < 8);
    if (e != 0) chk("latency", n, e);
    if (e == 8) chk("no vector", vl, 0);
    if (e < 8) chk("vector", va, a);
  endtask
  task fire(logic [7:0] m, logic ext, int e, logic [20:0] a);
    @(posedge CLK);
    if (ext) sx <= m;
    else se <= m;
    wv(e, a);
  endtask
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    #1;
    chk("reset", {fl, ple, gh, gl, vl, sp, ss}, 0);
    fire(8'h02, 0, 8, 0);
    chk("flag", fl, 8'h02);
    strobe(8'h02, 0, 3'b010, 3'b010);
    fire(8'h08, 0, 2, 21'h000008);
    chk("entry", {gh, sp, st, ss}, {1'b0, 5'h01, 21'h000100, TLIPU_IN_HIGH});
    strobe(0, 1, 0, 0);
    chk("ret", {gh, sp, ss}, {1'b1, 5'h00, TLIPU_IDLE});
    wv(0, 21'h000008);
    strobe(8'h08, 1, 0, 0);
    fire(8'h04, 0, 8, 0);
    strobe(0, 0, 3'b001, 3'b001);
    wv(0, 21'h000008);
    strobe(8'h04, 1, 0, 0);
    strobe(0, 0, 3'b111, 3'b111);
    fire(8'h08, 0, 2, 21'h000018);
    chk("low", {gl, ss}, {1'b0, TLIPU_IN_LOW});
    fire(8'h10, 0, 2, 21'h000008);
    chk("nest", {sp, st, ss}, {5'h02, 21'h000018, TLIPU_IN_BOTH});
    fire(8'h20, 0, 8, 0);
    strobe(8'h18, 1, 0, 0);
    chk("ret high", {gh, gl, ss}, {1'b1, 1'b0, TLIPU_IN_LOW});
    strobe(8'h20, 1, 0, 0);
    fire(8'hc0, 0, 2, 21'h000008);
    strobe(8'hc0, 1, 0, 0);
    @(posedge CLK);
    slp <= 1'b1;
    fire(8'h01, 1, 4, 21'h000008);
    chk("wake", {wk, fl[0], sp}, {1'b1, 1'b1, 5'h01});
    give_verdict();
  end
endmodule
